// *** rtl/dgcs_config_status.v ***
// General configuration and status register group of the deserializer hub
`timescale 1ns/1ps
`default_nettype none
`include "dgcs_consts.vh"

// Operation
// - Proxy host passes remote I2C only when enabled
// - Policy zero, no lock: output port high-impedance
// - Policy one, no lock, idle select one, drive enabled: port runs, LP-11 idle
// - Policy one: port follows its transmit control unless idle select one with drive disabled
// - Idle select one, drive disabled: outputs high-impedance
// - Policy one, lock low, idle select zero: outputs HS-0
// - Parity checked only while enable set; default on
// - Override forces reference clock reported present
// - Checksum status set after init if valid
// - Load complete bit set once init finished
// - Frequency valid only between 12 and 64 MHz
// - Pass status bit mirrors pass pin
// - Lock status bit mirrors lock pin
// - Per-port parity fault when errors reach limit
// - Limit high byte register, reset 0x01
// - Limit low byte register, reset zero
module dgcs_config_status #(
  parameter NUM_RX = 2,
  parameter NUM_TX = 2,
  parameter [3:0] SILICON_REVISION = 4'h5, // Arbitrary value
  parameter [3:0] MASK_REVISION = 4'h9 // Arbitrary value
) (
  input wire clk,
  input wire rst,
  // Register access port
  input wire reg_wr,
  input wire reg_rd,
  input wire [`DGCS_ADDR_W-1:0] reg_addr,
  input wire [`DGCS_DATA_W-1:0] reg_wdata,
  output reg [`DGCS_DATA_W-1:0] reg_rdata,
  // Device state inputs, from other clock domains or pins
  input wire init_done,
  input wire cksum_valid,
  input wire ref_detect,
  input wire ref_freq_in_range,
  input wire pass_pin,
  input wire lock_pin,
  input wire [NUM_RX-1:0] rx_lock,
  input wire [NUM_RX*NUM_TX-1:0] port_assign,
  // Parity error events from the receive ports, same clock
  input wire [NUM_RX-1:0] rx_parity_err,
  input wire [NUM_RX-1:0] parity_fault_clr,
  // Remote I2C proxy gating
  input wire remote_i2c_req,
  output wire remote_i2c_grant,
  output wire remote_i2c_block,
  // Camera transmit side
  input wire [NUM_TX-1:0] tx_ctrl_enable,
  output reg [2*NUM_TX-1:0] tx_out_state,
  output reg [NUM_TX-1:0] tx_run,
  // Configuration outputs
  output wire parity_check_en,
  output wire ref_present,
  output wire [15:0] parity_error_limit,
  output reg [NUM_RX-1:0] parity_fault
);

  reg [`DGCS_DATA_W-1:0] gencfg_q;
  reg [`DGCS_DATA_W-1:0] lim_hi_q;
  reg [`DGCS_DATA_W-1:0] lim_lo_q;
  reg [15:0] err_cnt_q [0:NUM_RX-1];

  // Two-flop synchronisers for asynchronous status levels
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [NUM_RX-1:0] lock_s1_q;
  reg [NUM_RX-1:0] lock_s2_q;

  wire init_s = sync2_q[0];
  wire cksum_s = sync2_q[1];
  wire ref_det_s = sync2_q[2];
  wire pass_s = sync2_q[3];
  wire lockpin_s = sync2_q[4];
  reg ref_valid_q;
  reg init_q;
  reg cksum_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      lock_s1_q <= {NUM_RX{1'b0}};
      lock_s2_q <= {NUM_RX{1'b0}};
      ref_valid_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {lock_pin, pass_pin, ref_detect, cksum_valid, init_done};
      sync2_q <= sync1_q;
      lock_s1_q <= rx_lock;
      lock_s2_q <= lock_s1_q;
      // Range detector result, sampled through the synchroniser below
      ref_valid_q <= ref_freq_in_range;
    end
  end

  // Frequency valid needs its own second stage
  reg ref_valid_s_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      ref_valid_s_q <= 1'b0;
    else
      ref_valid_s_q <= ref_valid_q;
  end

  // Checksum result is captured when init completes, not before
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      init_q <= 1'b0;
      cksum_q <= 1'b0;
    end
    else
    begin
      init_q <= init_s;
      if (init_s && !init_q)
        cksum_q <= cksum_s;
      else if (!init_s)
        cksum_q <= 1'b0;
    end
  end

  // Register writes; read-only offsets fall through untouched
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gencfg_q <= `DGCS_GEN_RESET;
      lim_hi_q <= `DGCS_LIM_HI_RESET;
      lim_lo_q <= `DGCS_LIM_LO_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `DGCS_OFF_GENCFG: gencfg_q <= reg_wdata;
        `DGCS_OFF_LIM_HI: lim_hi_q <= reg_wdata;
        `DGCS_OFF_LIM_LO: lim_lo_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign parity_error_limit = {lim_hi_q, lim_lo_q};

  wire proxy_en = gencfg_q[`DGCS_GEN_PROXY];
  wire unlk_pol = gencfg_q[`DGCS_GEN_UNLK_POL];
  wire out_en = gencfg_q[`DGCS_GEN_OUT_EN];
  wire idle_sel = gencfg_q[`DGCS_GEN_IDLE_SEL];

  assign remote_i2c_grant = remote_i2c_req & proxy_en;
  assign remote_i2c_block = remote_i2c_req & ~proxy_en;
  assign parity_check_en = gencfg_q[`DGCS_GEN_PAR_EN];
  assign ref_present = gencfg_q[`DGCS_GEN_REF_OVR] | ref_det_s;

  // Status register image
  wire [`DGCS_DATA_W-1:0] sts_img;
  assign sts_img = {cksum_q, init_q, 1'b0, ref_valid_s_q,
    pass_s, lockpin_s, `DGCS_STS_RSV_LOW};

  // Camera output port policy, one decision per port
  genvar t;
  generate
    for (t = 0; t < NUM_TX; t = t + 1)
    begin : g_tx
      wire any_lock;
      assign any_lock = |(lock_s2_q & port_assign[t*NUM_RX +: NUM_RX]);
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          tx_out_state[2*t +: 2] <= `DGCS_OUT_HIZ;
          tx_run[t] <= 1'b0;
        end
        else if (idle_sel && !out_en)
        begin
          // Drive disable with idle select one overrides every other choice
          tx_out_state[2*t +: 2] <= `DGCS_OUT_HIZ;
          tx_run[t] <= 1'b0;
        end
        else if (!any_lock && !unlk_pol)
        begin
          tx_out_state[2*t +: 2] <= `DGCS_OUT_HIZ;
          tx_run[t] <= 1'b0;
        end
        else if (!any_lock && !idle_sel)
        begin
          tx_out_state[2*t +: 2] <= `DGCS_OUT_HS0;
          tx_run[t] <= tx_ctrl_enable[t];
        end
        else if (!any_lock)
        begin
          tx_out_state[2*t +: 2] <= `DGCS_OUT_LP11;
          tx_run[t] <= tx_ctrl_enable[t];
        end
        else
        begin
          tx_out_state[2*t +: 2] <= `DGCS_OUT_NORMAL;
          tx_run[t] <= tx_ctrl_enable[t];
        end
      end
    end
  endgenerate

  // Per-port parity error counters and sticky fault flags
  genvar p;
  generate
    for (p = 0; p < NUM_RX; p = p + 1)
    begin : g_rx
      wire count_err;
      wire [15:0] cnt_next;
      assign count_err = rx_parity_err[p] & parity_check_en;
      // Counter saturates so a long burst never wraps below the limit
      assign cnt_next = (err_cnt_q[p] == `DGCS_ERRCNT_MAX) ? err_cnt_q[p]
        : err_cnt_q[p] + `DGCS_ERRCNT_ONE;
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          err_cnt_q[p] <= `DGCS_ERRCNT_ZERO;
          parity_fault[p] <= 1'b0;
        end
        else
        begin
          if (parity_fault_clr[p] && !count_err)
            err_cnt_q[p] <= `DGCS_ERRCNT_ZERO;
          else if (count_err)
            err_cnt_q[p] <= cnt_next;
          // Set wins over a clear in the same cycle; a clear with no new
          // error also empties the counter, so the stale count must not re-set
          if (err_cnt_q[p] >= parity_error_limit && !parity_fault_clr[p])
            parity_fault[p] <= 1'b1;
          else if (count_err && cnt_next >= parity_error_limit)
            parity_fault[p] <= 1'b1;
          else if (parity_fault_clr[p])
            parity_fault[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered read data; unmapped offsets read zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `DGCS_RD_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        `DGCS_OFF_GENCFG: reg_rdata <= gencfg_q;
        `DGCS_OFF_REV: reg_rdata <= {SILICON_REVISION, MASK_REVISION};
        `DGCS_OFF_STS: reg_rdata <= sts_img;
        `DGCS_OFF_LIM_HI: reg_rdata <= lim_hi_q;
        `DGCS_OFF_LIM_LO: reg_rdata <= lim_lo_q;
        default: reg_rdata <= `DGCS_RD_ZERO;
      endcase
    end
  end

endmodule // dgcs_config_status
`default_nettype wire

// *** rtl/dgcs_consts.vh ***
// Register offsets, field positions and reset values of the config/status group
`ifndef DGCS_CONSTS_VH
`define DGCS_CONSTS_VH

`define DGCS_ADDR_W 8
`define DGCS_DATA_W 8
`define DGCS_OFF_GENCFG 8'h02
`define DGCS_OFF_REV 8'h03
`define DGCS_OFF_STS 8'h04
`define DGCS_OFF_LIM_HI 8'h05
`define DGCS_OFF_LIM_LO 8'h06

`define DGCS_GEN_RSV_HI 7
`define DGCS_GEN_RSV_LO 6
`define DGCS_GEN_PROXY 5
`define DGCS_GEN_UNLK_POL 4
`define DGCS_GEN_OUT_EN 3
`define DGCS_GEN_IDLE_SEL 2
`define DGCS_GEN_PAR_EN 1
`define DGCS_GEN_REF_OVR 0
`define DGCS_GEN_RESET 8'h1e

`define DGCS_STS_CKSUM 7
`define DGCS_STS_INIT 6
`define DGCS_STS_REFVAL 4
`define DGCS_STS_PASS 3
`define DGCS_STS_LOCK 2
`define DGCS_STS_RSV_LOW 2'h3

`define DGCS_LIM_HI_RESET 8'h01
`define DGCS_LIM_LO_RESET 8'h00

`define DGCS_RD_ZERO 8'h00
`define DGCS_ERRCNT_ZERO 16'h0000
`define DGCS_ERRCNT_ONE 16'h0001
`define DGCS_ERRCNT_MAX 16'hffff

// Camera output port states
`define DGCS_OUT_NORMAL 2'h0
`define DGCS_OUT_HIZ 2'h1
`define DGCS_OUT_LP11 2'h2
`define DGCS_OUT_HS0 2'h3

`endif

// *** verif/dgcs_checker.sv ***
// Checker of register bus and configuration outputs
`timescale 1ns/1ps
`default_nettype none
module dgcs_checker (
  input wire clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire remote_i2c_req,
  input wire remote_i2c_grant,
  input wire remote_i2c_block,
  input wire parity_check_en,
  input wire ref_present,
  input wire [15:0] parity_error_limit
);
  logic [7:0] g_q;
  logic [15:0] l_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of what the host wrote
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      g_q <= 8'h1e;
      l_q <= 16'h0100;
    end
    else if (reg_wr && reg_addr == 8'h02)
      g_q <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h05)
      l_q[15:8] <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h06)
      l_q[7:0] <= reg_wdata;
  end
  AST_PROXY: assert property (remote_i2c_grant == (remote_i2c_req & g_q[5]))
    else $error("proxy grant wrong");
  AST_BLOCK: assert property (remote_i2c_block == (remote_i2c_req & !g_q[5]))
    else $error("proxy block wrong");
  AST_PAR: assert property (parity_check_en == g_q[1])
    else $error("parity enable wrong");
  AST_REF: assert property (g_q[0] |-> ref_present)
    else $error("reference not forced");
  AST_LIM: assert property (parity_error_limit == l_q)
    else $error("limit wrong");
  AST_RD_HI: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata == l_q[15:8])
    else $error("high byte read wrong");
  AST_RD_LO: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata == l_q[7:0])
    else $error("low byte read wrong");
  AST_UNMAP: assert property (reg_rd && reg_addr > 8'h06 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // dgcs_checker
`default_nettype wire

// *** verif/dgcs_host_model.sv ***
// Host model issuing register strobes at the falling edge
`timescale 1ns/1ps
`default_nettype none
module dgcs_host_model (
  input wire clk,
  input wire [7:0] reg_rdata,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Stale data would hide a missed write
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule // dgcs_host_model
`default_nettype wire

// *** verif/deser_general_config_status_tb_top.sv ***
// Testbench of the config/status register group
`timescale 1ns/1ps
`default_nettype none
module deser_general_config_status_tb_top;
  typedef struct {logic [7:0] a, d, r; logic [1:0] s;} dgcs_row_t;
  logic clk = 1'b0, rst = 1'b1, init_done = 1'b0, cksum_valid = 1'b0;
  logic ref_detect = 1'b0, ref_freq_in_range = 1'b0, pass_pin = 1'b0;
  logic lock_pin = 1'b0, remote_i2c_req = 1'b0;
  logic [1:0] rx_lock = 2'b00, rx_parity_err = 2'b00;
  logic [1:0] parity_fault_clr = 2'b00, tx_ctrl_enable = 2'b11;
  logic [3:0] port_assign = 4'hf, tx_out_state;
  logic [1:0] tx_run, parity_fault;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [15:0] parity_error_limit;
  logic reg_wr, reg_rd, remote_i2c_grant, remote_i2c_block;
  logic parity_check_en, ref_present;
  int n_errors = 0, cmp_count = 0;
  dgcs_row_t rows [8] = '{'{8'h02, 8'h0e, 8'h0e, 2'h1},
    '{8'h02, 8'h1a, 8'h1a, 2'h3}, '{8'h02, 8'h16, 8'h16, 2'h1},
    '{8'h02, 8'h1e, 8'h1e, 2'h2}, '{8'h05, 8'ha5, 8'ha5, 2'h2},
    '{8'h06, 8'h3c, 8'h3c, 2'h2}, '{8'h03, 8'hff, 8'h74, 2'h2},
    '{8'h08, 8'hff, 8'h00, 2'h2}};
  always #5 clk = ~clk;
  dgcs_host_model dgcs_host_model_inst (.clk, .reg_rdata, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata);
  // Revision values are arbitrary
  dgcs_config_status #(.SILICON_REVISION(4'h7), .MASK_REVISION(4'h4))
    dgcs_config_status_inst (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .init_done, .cksum_valid, .ref_detect,
    .ref_freq_in_range, .pass_pin, .lock_pin, .rx_lock, .port_assign,
    .rx_parity_err, .parity_fault_clr, .remote_i2c_req, .remote_i2c_grant,
    .remote_i2c_block, .tx_ctrl_enable, .tx_out_state, .tx_run,
    .parity_check_en, .ref_present, .parity_error_limit, .parity_fault);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input logic [1:0] p, input int n);
    repeat (n)
    begin
      @(negedge clk);
      rx_parity_err = p;
      @(negedge clk);
      rx_parity_err = 2'b00;
    end
    @(negedge clk);
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    dgcs_host_model_inst.rd(8'h05, v);
    chk("limit high reset", 16'h01, 16'(v));
    foreach (rows[i])
    begin
      dgcs_host_model_inst.wr(rows[i].a, rows[i].d);
      dgcs_host_model_inst.rd(rows[i].a, v);
      chk("readback", 16'(rows[i].r), 16'(v));
      repeat (4) @(negedge clk);
      chk("tx state", 16'({2{rows[i].s}}), 16'(tx_out_state));
    end
    {init_done, cksum_valid, ref_freq_in_range, lock_pin} = 4'hf;
    rx_lock = 2'b11;
    for (int k = 0; k < 20 && !v[6]; k++)
      dgcs_host_model_inst.rd(8'h04, v);
    chk("load done", 16'h1, 16'(v[6]));
    dgcs_host_model_inst.wr(8'h04, 8'h00);
    dgcs_host_model_inst.rd(8'h04, v);
    chk("status", 16'hd7, 16'(v));
    chk("locked run", 16'h3, 16'({tx_out_state, tx_run}));
    remote_i2c_req = 1'b1;
    dgcs_host_model_inst.wr(8'h02, 8'h3f);
    chk("proxy", 16'h5, 16'({remote_i2c_grant, remote_i2c_block, ref_present}));
    dgcs_host_model_inst.wr(8'h05, 8'h00);
    dgcs_host_model_inst.wr(8'h06, 8'h02);
    pulse(2'b01, 1);
    chk("fault early", 16'h0, 16'(parity_fault));
    pulse(2'b01, 1);
    chk("fault at limit", 16'h1, 16'(parity_fault));
    parity_fault_clr = 2'b01;
    @(negedge clk);
    parity_fault_clr = 2'b00;
    chk("fault cleared", 16'h0, 16'(parity_fault));
    dgcs_host_model_inst.wr(8'h02, 8'h3d);
    pulse(2'b11, 3);
    chk("check off", 16'h0, 16'(parity_fault));
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    dgcs_host_model_inst.rd(8'h02, v);
    chk("config reset", 16'h1e, 16'(v));
    results();
  end
endmodule // deser_general_config_status_tb_top
bind dgcs_config_status dgcs_checker dgcs_checker_inst (.clk, .rst, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .remote_i2c_req,
  .remote_i2c_grant, .remote_i2c_block, .parity_check_en, .ref_present,
  .parity_error_limit);
`default_nettype wire
